// ===== core/trio_io_top.sv
// trio_io_top: encoders, pwm drives, thermal cutoff, adc and registers.
// assumes a single-cycle register port and a serial adc with 12-bit frames.
`timescale 1ns/1ps
`default_nettype none
module trio_io_top import trio_pkg::*; #(
  parameter int unsigned POS_W = 32,
  parameter logic [31:0] VERSION_ID = 32'h00000001 // arbitrary value
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic [1:0] encA,
  input wire logic [1:0] encB,
  input wire logic [1:0] overheat,
  output logic [1:0] pwmOut,
  output logic [1:0] dirOut,
  output logic [1:0] brakeOut,
  output logic adcCs_n,
  output logic adcSclk,
  output logic adcChan,
  input wire logic adcDout,
  output logic irq
);
  // ==========================================================
  // software registers
  logic [1:0] clear_reg;
  logic [10:0] dutyAz_reg;
  logic [10:0] dutyPi_reg;
  logic [5:0] divAz_reg;
  logic [5:0] divPi_reg;
  logic [1:0] cutoff_reg;
  logic [1:0] brake_reg;
  logic [IRQ_W-1:0] irqStat_reg;
  logic [IRQ_W-1:0] irqMask_reg;
  logic [ADC_BITS-1:0] adcAz_reg;
  logic [ADC_BITS-1:0] adcPi_reg;
  logic [POS_W-1:0] pos [2];
  logic [1:0] ovh_reg;

  // control register writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clear_reg <= CLEAR_RST;
      dutyAz_reg <= DUTY_RST;
      dutyPi_reg <= DUTY_RST;
      divAz_reg <= DIVIDER_RST;
      divPi_reg <= DIVIDER_RST;
      cutoff_reg <= CUTOFF_RST;
      brake_reg <= 2'h0;
      irqMask_reg <= IRQ_RST;
    end else if (regWrite) begin
      if (regAddr == ADDR_CLEAR) begin
        clear_reg <= regWdata[1:0];
      end else if (regAddr == ADDR_DUTY_AZ) begin
        dutyAz_reg <= regWdata[10:0];
      end else if (regAddr == ADDR_DUTY_PI) begin
        dutyPi_reg <= regWdata[10:0];
      end else if (regAddr == ADDR_DIVIDER) begin
        divAz_reg <= regWdata[5:0];
        divPi_reg <= regWdata[13:8];
      end else if (regAddr == ADDR_CUTOFF) begin
        cutoff_reg <= regWdata[1:0];
      end else if (regAddr == ADDR_BRAKE) begin
        brake_reg <= regWdata[1:0];
      end else if (regAddr == ADDR_IRQ_MASK) begin
        irqMask_reg <= regWdata[IRQ_W-1:0];
      end
    end
  end

  // ==========================================================
  // encoder counters, one per axis
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_axis
      trio_quad_counter #(.WIDTH(POS_W)) u_cnt (
        .clk(clk),
        .reset_n(reset_n),
        .encA(encA[gi]),
        .encB(encB[gi]),
        .clearHold(clear_reg[gi]),
        .position(pos[gi])
      );
    end
  endgenerate

  // ==========================================================
  // pwm reference tick: 40 MHz enable from the 200 MHz clock
  logic [3:0] refCnt_reg;
  logic refTick;
  assign refTick = (refCnt_reg == 4'(REF_DIV - 1));
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      refCnt_reg <= 4'h0;
    end else begin
      refCnt_reg <= refTick ? 4'h0 : refCnt_reg + 4'h1;
    end
  end

  // overheat input registered; cutoff gating needs both bits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovh_reg <= 2'h0;
    end else begin
      ovh_reg <= overheat;
    end
  end
  logic [1:0] block;
  assign block = cutoff_reg & ovh_reg;

  trio_pwm_gen u_pwmAz (
    .clk(clk),
    .reset_n(reset_n),
    .refTick(refTick),
    .duty(dutyAz_reg),
    .divider(divAz_reg),
    .brakeReq(brake_reg[0]),
    .block(block[0]),
    .pwmOut(pwmOut[0]),
    .dirOut(dirOut[0]),
    .brakeOut(brakeOut[0])
  );
  trio_pwm_gen u_pwmPi (
    .clk(clk),
    .reset_n(reset_n),
    .refTick(refTick),
    .duty(dutyPi_reg),
    .divider(divPi_reg),
    .brakeReq(brake_reg[1]),
    .block(block[1]),
    .pwmOut(pwmOut[1]),
    .dirOut(dirOut[1]),
    .brakeOut(brakeOut[1])
  );

  // ==========================================================
  // adc: alternating channel frames, 12 bits msb first
  trio_adc_state_t adcState_reg;
  logic [3:0] sclkCnt_reg;
  logic [3:0] bitCnt_reg;
  logic [ADC_BITS-1:0] shift_reg;
  logic sclkEdge;
  assign sclkEdge = (sclkCnt_reg == 4'(ADC_SCLK_DIV - 1));
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclkCnt_reg <= 4'h0;
    end else begin
      sclkCnt_reg <= sclkEdge ? 4'h0 : sclkCnt_reg + 4'h1;
    end
  end
  // sclk high in second half of each bit, sample on its falling edge
  assign adcSclk = (adcState_reg == TRIO_ADC_SHIFT) && (sclkCnt_reg >= 4'(ADC_SCLK_DIV / 2));
  assign adcCs_n = (adcState_reg != TRIO_ADC_SHIFT);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      adcState_reg <= TRIO_ADC_IDLE;
      bitCnt_reg <= 4'h0;
      shift_reg <= '0;
      adcChan <= 1'b0;
      adcAz_reg <= '0;
      adcPi_reg <= '0;
    end else if (sclkEdge) begin
      case (adcState_reg)
        TRIO_ADC_IDLE: begin
          adcState_reg <= TRIO_ADC_SHIFT;
          bitCnt_reg <= 4'h0;
        end
        TRIO_ADC_SHIFT: begin
          shift_reg <= {shift_reg[ADC_BITS-2:0], adcDout};
          bitCnt_reg <= bitCnt_reg + 4'h1;
          if (bitCnt_reg == 4'(ADC_BITS - 1)) begin
            adcState_reg <= TRIO_ADC_DONE;
          end
        end
        TRIO_ADC_DONE: begin
          if (adcChan) begin
            adcPi_reg <= shift_reg;
          end else begin
            adcAz_reg <= shift_reg;
          end
          adcChan <= !adcChan;
          adcState_reg <= TRIO_ADC_IDLE;
        end
        default: adcState_reg <= TRIO_ADC_IDLE;
      endcase
    end
  end
  logic adcDone;
  assign adcDone = sclkEdge && (adcState_reg == TRIO_ADC_DONE);

  // ==========================================================
  // interrupts: overheat rise and adc sample done; set wins over clear
  logic [1:0] ovhPrev_reg;
  logic [IRQ_W-1:0] irqEvt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovhPrev_reg <= 2'h0;
    end else begin
      ovhPrev_reg <= ovh_reg;
    end
  end
  assign irqEvt = {adcDone && adcChan, adcDone && !adcChan, ovh_reg & ~ovhPrev_reg};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStat_reg <= IRQ_RST;
    end else begin
      if (regWrite && regAddr == ADDR_IRQ_STAT) begin
        irqStat_reg <= (irqStat_reg & ~regWdata[IRQ_W-1:0]) | irqEvt;
      end else begin
        irqStat_reg <= irqStat_reg | irqEvt;
      end
    end
  end
  assign irq = |(irqStat_reg & irqMask_reg);

  // ==========================================================
  // read port: data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= 32'h00000000;
    end else if (regRead) begin
      if (regAddr == ADDR_VERSION) begin
        regRdata <= VERSION_ID;
      end else if (regAddr == ADDR_POS_AZ) begin
        regRdata <= 32'(pos[0]);
      end else if (regAddr == ADDR_POS_PI) begin
        regRdata <= 32'(pos[1]);
      end else if (regAddr == ADDR_POS_BOTH) begin
        regRdata <= {pos[0][15:0], pos[1][15:0]};
      end else if (regAddr == ADDR_CLEAR) begin
        regRdata <= {30'h0, clear_reg};
      end else if (regAddr == ADDR_DUTY_AZ) begin
        regRdata <= {21'h0, dutyAz_reg};
      end else if (regAddr == ADDR_DUTY_PI) begin
        regRdata <= {21'h0, dutyPi_reg};
      end else if (regAddr == ADDR_DIVIDER) begin
        regRdata <= {18'h0, divPi_reg, 2'h0, divAz_reg};
      end else if (regAddr == ADDR_CUTOFF) begin
        regRdata <= {30'h0, cutoff_reg};
      end else if (regAddr == ADDR_THERM) begin
        regRdata <= {30'h0, ovh_reg};
      end else if (regAddr == ADDR_BRAKE) begin
        regRdata <= {30'h0, brake_reg};
      end else if (regAddr == ADDR_ADC) begin
        regRdata <= {4'h0, adcPi_reg, 4'h0, adcAz_reg};
      end else if (regAddr == ADDR_IRQ_STAT) begin
        regRdata <= {28'h0, irqStat_reg};
      end else if (regAddr == ADDR_IRQ_MASK) begin
        regRdata <= {28'h0, irqMask_reg};
      end else begin
        regRdata <= 32'h00000000;
      end
    end
  end
endmodule // trio_io_top
`default_nettype wire

// ===== core/trio_pkg.sv
// trio_pkg: shared constants for the two-axis encoder / pwm io block.
// assumes a single 200 MHz system clock; all other rates are enables.
package trio_pkg;
  // ==========================================================
  // clocking and timing
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned PWM_REF_HZ = 40000000; // pwm reference tick rate
  localparam int unsigned REF_DIV = CLK_HZ / PWM_REF_HZ; // system cycles per tick
  localparam int unsigned PWM_TOP = 1023; // ticks per pwm period
  localparam int unsigned PRESC_MAX = 63;
  // ==========================================================
  // register map (byte addresses, one word each)
  localparam logic [7:0] ADDR_VERSION = 8'h00;
  localparam logic [7:0] ADDR_POS_AZ = 8'h04;
  localparam logic [7:0] ADDR_POS_PI = 8'h08;
  localparam logic [7:0] ADDR_POS_BOTH = 8'h0c;
  localparam logic [7:0] ADDR_CLEAR = 8'h10;
  localparam logic [7:0] ADDR_DUTY_AZ = 8'h14;
  localparam logic [7:0] ADDR_DUTY_PI = 8'h18;
  localparam logic [7:0] ADDR_DIVIDER = 8'h1c;
  localparam logic [7:0] ADDR_CUTOFF = 8'h20;
  localparam logic [7:0] ADDR_THERM = 8'h24;
  localparam logic [7:0] ADDR_BRAKE = 8'h28;
  localparam logic [7:0] ADDR_ADC = 8'h2c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h30;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h34;
  // ==========================================================
  // reset values
  localparam logic [1:0] CLEAR_RST = 2'h0;
  localparam logic [1:0] CUTOFF_RST = 2'h3;
  localparam logic [5:0] DIVIDER_RST = 6'h00;
  localparam logic [10:0] DUTY_RST = 11'h000;
  // interrupt status bits: [1:0] overheat per axis, [3:2] adc sample per axis
  localparam int unsigned IRQ_W = 4;
  localparam logic [3:0] IRQ_RST = 4'h0;
  // adc frame states
  typedef enum logic [1:0] {
    TRIO_ADC_IDLE = 2'b00,
    TRIO_ADC_SHIFT = 2'b01,
    TRIO_ADC_DONE = 2'b10
  } trio_adc_state_t;
  localparam int unsigned ADC_BITS = 12;
  localparam int unsigned ADC_SCLK_DIV = 10; // system cycles per adc bit
endpackage : trio_pkg

// ===== core/trio_pwm_gen.sv
// trio_pwm_gen: one pwm channel with prescaler, direction and brake.
// assumes refTick is a one-cycle enable at the pwm reference rate.
`timescale 1ns/1ps
`default_nettype none
module trio_pwm_gen import trio_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic refTick,
  input wire logic [10:0] duty,
  input wire logic [5:0] divider,
  input wire logic brakeReq,
  input wire logic block,
  output logic pwmOut,
  output logic dirOut,
  output logic brakeOut
);
  // ==========================================================
  // duty is sign + 10-bit magnitude; settings latched once per period
  logic [5:0] presc_reg;
  logic [9:0] tick_reg;
  logic [9:0] mag_reg;
  logic [5:0] divAct_reg;
  logic periodEnd;
  logic stepEn;
  assign stepEn = refTick && (presc_reg == divAct_reg);
  assign periodEnd = stepEn && (tick_reg == 10'(PWM_TOP - 1));
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      presc_reg <= DIVIDER_RST;
    end else if (refTick) begin
      presc_reg <= stepEn ? 6'h00 : presc_reg + 6'h01;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_reg <= 10'h000;
    end else if (stepEn) begin
      tick_reg <= periodEnd ? 10'h000 : tick_reg + 10'h001;
    end
  end
  // new settings only at period boundary, so no runt pulses
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mag_reg <= 10'h000;
      dirOut <= 1'b0;
      divAct_reg <= DIVIDER_RST;
      brakeOut <= 1'b0;
    end else if (periodEnd) begin
      mag_reg <= duty[9:0];
      dirOut <= duty[10];
      divAct_reg <= divider;
      brakeOut <= brakeReq;
    end
  end
  // zero magnitude gives no drive; overheat cutoff kills the wave
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwmOut <= 1'b0;
    end else begin
      pwmOut <= !block && (tick_reg < mag_reg);
    end
  end
endmodule // trio_pwm_gen
`default_nettype wire

// ===== core/trio_quad_counter.sv
// trio_quad_counter: one quadrature position counter.
// assumes encoder pins may be asynchronous; they are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module trio_quad_counter import trio_pkg::*; #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic encA,
  input wire logic encB,
  input wire logic clearHold,
  output logic [WIDTH-1:0] position
);
  // ==========================================================
  // synchroniser: stage one read only by stage two
  logic [1:0] syncA_reg;
  logic [1:0] syncB_reg;
  logic [1:0] prev_reg;
  logic [1:0] cur;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA_reg <= 2'h0;
      syncB_reg <= 2'h0;
      prev_reg <= 2'h0;
    end else begin
      syncA_reg <= {syncA_reg[0], encA};
      syncB_reg <= {syncB_reg[0], encB};
      prev_reg <= cur;
    end
  end
  assign cur = {syncA_reg[1], syncB_reg[1]};
  // ==========================================================
  // x4 decode: gray step tells direction, double steps are dropped
  logic up;
  logic down;
  always_comb begin
    up = 1'b0;
    down = 1'b0;
    case ({prev_reg, cur})
      4'b0010, 4'b1011, 4'b1101, 4'b0100: up = 1'b1;
      4'b0001, 4'b0111, 4'b1110, 4'b1000: down = 1'b1;
      default: begin
        up = 1'b0;
        down = 1'b0;
      end
    endcase
  end
  // wraps in two's complement; clear held while flag set
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      position <= '0;
    end else if (clearHold) begin
      position <= '0;
    end else if (up) begin
      position <= position + WIDTH'(1);
    end else if (down) begin
      position <= position - WIDTH'(1);
    end
  end
endmodule // trio_quad_counter
`default_nettype wire

// ===== verif/tb_top.sv
// tb_top: register-level tests of trio_io_top with an adc model.
// assumes 200 MHz clock and the register map of trio_pkg.
`timescale 1ns/1ps
`default_nettype none
module tb_top import trio_pkg::*;;
  localparam logic [31:0] VER = 32'h0000005a; // arbitrary value
  localparam int P0 = PWM_TOP * REF_DIV;
  logic clk, reset_n, regWrite, regRead, adcCs_n, adcSclk, adcChan, adcDout, irq;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic [1:0] encA, encB, overheat, pwmOut, dirOut, brakeOut;
  logic [1:0] ph [2];
  logic [31:0] hi [2];
  logic [31:0] rise [2];
  int n_errors = 0;
  int samples_checked = 0;
  trio_io_top #(.VERSION_ID(VER)) DUT (
    .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .encA(encA),
    .encB(encB), .overheat(overheat), .pwmOut(pwmOut), .dirOut(dirOut),
    .brakeOut(brakeOut), .adcCs_n(adcCs_n), .adcSclk(adcSclk),
    .adcChan(adcChan), .adcDout(adcDout), .irq(irq)
  );
  trio_adc_model u_adc (
    .adcCs_n(adcCs_n), .adcSclk(adcSclk), .adcChan(adcChan), .adcDout(adcDout)
  );
  always #2.5 clk = ~clk;
  // ==========================================================
  // bus and compare tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(regRdata, e);
  endtask
  // quadrature steps, 4 cycles apart; negative n turns backwards
  task automatic step(input int ax, input int n);
    repeat (n < 0 ? -n : n) begin
      ph[ax] = (n < 0) ? ph[ax] - 2'h1 : ph[ax] + 2'h1;
      @(posedge clk);
      encA[ax] <= ^ph[ax];
      encB[ax] <= ph[ax][1];
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask
  // high cycles and rising edges of both pwm outputs over n cycles
  task automatic win(input int n);
    logic [1:0] prev;
    hi = '{32'h0, 32'h0};
    rise = '{32'h0, 32'h0};
    @(posedge clk);
    #1;
    prev = pwmOut;
    repeat (n) begin
      @(posedge clk);
      #1;
      for (int i = 0; i < 2; i++) begin
        hi[i] = hi[i] + 32'(pwmOut[i]);
        rise[i] = rise[i] + 32'(pwmOut[i] & ~prev[i]);
      end
      prev = pwmOut;
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    encA = 2'h0;
    encB = 2'h0;
    overheat = 2'h0;
    ph = '{2'h0, 2'h0};
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    // identity, reset values, refused accesses
    rdchk(ADDR_VERSION, VER);
    wr(ADDR_VERSION, 32'h0000abcd);
    rdchk(ADDR_VERSION, VER);
    rdchk(ADDR_CUTOFF, {30'h0, CUTOFF_RST});
    rdchk(8'h3c, 32'h0);
    // counting both ways, negative value, combined view
    step(0, 6);
    step(1, -3);
    rdchk(ADDR_POS_AZ, 32'h00000006);
    rdchk(ADDR_POS_PI, 32'hfffffffd);
    rdchk(ADDR_POS_BOTH, 32'h0006fffd);
    // host zeroes at the rest position, then releases azimuth only
    wr(ADDR_CLEAR, 32'h3);
    step(0, 2);
    rdchk(ADDR_POS_BOTH, 32'h0);
    rdchk(ADDR_POS_AZ, 32'h0);
    wr(ADDR_CLEAR, 32'h2);
    step(0, -2);
    step(1, 1);
    rdchk(ADDR_POS_BOTH, 32'hfffe0000);
    // duty 10 ticks azimuth at divider 0, 20 ticks reversed pitch at divider 1
    wr(ADDR_DUTY_AZ, 32'h0000000a);
    wr(ADDR_DUTY_PI, 32'h00000414);
    wr(ADDR_DIVIDER, 32'h00000100);
    wr(ADDR_BRAKE, 32'h00000002);
    repeat (2 * P0) @(posedge clk);
    win(4 * P0);
    chk(hi[0], 40 * REF_DIV);
    chk(rise[0], 32'h4);
    chk(hi[1], 80 * REF_DIV);
    chk(rise[1], 32'h2);
    chk({30'h0, dirOut}, 32'h2);
    chk({30'h0, brakeOut}, 32'h2);
    // azimuth amplifier overheats with cutoff enabled
    @(posedge clk);
    overheat <= 2'h1;
    repeat (4) @(posedge clk);
    win(2 * P0);
    chk(hi[0], 32'h0);
    chk(hi[1], 40 * REF_DIV);
    rdchk(ADDR_THERM, 32'h1);
    wr(ADDR_CUTOFF, 32'h2);
    repeat (10) @(posedge clk);
    win(2 * P0);
    chk(hi[0], 20 * REF_DIV);
    // converter values and interrupt sources
    rdchk(ADDR_ADC, 32'h00000fff);
    rdchk(ADDR_IRQ_STAT, 32'h0000000d);
    wr(ADDR_IRQ_MASK, 32'h1);
    #1;
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_STAT, 32'h1);
    #1;
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_MASK, 32'hc);
    #1;
    chk({31'h0, irq}, 32'h1);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire

// ===== verif/trio_adc_model.sv
// trio_adc_model: serial tacho converter seen at the block's adc pins.
// assumes bits are shifted on the rising adc clock while selected.
`timescale 1ns/1ps
`default_nettype none
module trio_adc_model (
  input wire logic adcCs_n,
  input wire logic adcSclk,
  input wire logic adcChan,
  output logic adcDout
);
  logic lastBit_reg;
  // ==========================================================
  // last bit on the line, so a released line never shows it again
  initial begin
    lastBit_reg = 1'b0;
  end
  always @(posedge adcSclk) begin
    if (!adcCs_n) lastBit_reg <= adcDout;
  end
  // azimuth all ones, pitch all zeros: bit order cannot mask a fault
  assign adcDout = adcCs_n ? ~lastBit_reg : ~adcChan;
endmodule // trio_adc_model
`default_nettype wire

// ===== verif/trio_io_properties.sv
// trio_io_properties: port-level checks for trio_io_top.
// assumes the register map of trio_pkg and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module trio_io_checker import trio_pkg::*; #(
  parameter logic [31:0] VERSION_ID = 32'h00000001 // arbitrary value
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire logic [1:0] overheat,
  input wire logic [1:0] pwmOut,
  input wire logic [1:0] dirOut,
  input wire logic [1:0] brakeOut,
  input wire logic adcCs_n,
  input wire logic adcSclk,
  input wire logic adcChan,
  input wire logic irq
);
  // slowest divider period plus margin
  localparam int LAG_MAX = 330000;
  logic [1:0] cut_reg, clr_reg, brk_reg, dir_reg;
  logic [3:0] mask_reg;
  logic [18:0] lag_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // shadow of host-written settings
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cut_reg <= CUTOFF_RST;
      clr_reg <= CLEAR_RST;
      brk_reg <= 2'h0;
      dir_reg <= 2'h0;
      mask_reg <= IRQ_RST;
    end else if (regWrite) begin
      if (regAddr == ADDR_CUTOFF) cut_reg <= regWdata[1:0];
      if (regAddr == ADDR_CLEAR) clr_reg <= regWdata[1:0];
      if (regAddr == ADDR_BRAKE) brk_reg <= regWdata[1:0];
      if (regAddr == ADDR_IRQ_MASK) mask_reg <= regWdata[3:0];
      if (regAddr == ADDR_DUTY_AZ) dir_reg[0] <= regWdata[10];
      if (regAddr == ADDR_DUTY_PI) dir_reg[1] <= regWdata[10];
    end
  end
  // cycles that direction or brake outputs lag their settings
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) lag_reg <= 19'h0;
    else if ({dirOut, brakeOut} != {dir_reg, brk_reg}) lag_reg <= lag_reg + 19'h1;
    else lag_reg <= 19'h0;
  end
  // ==========================================================
  // converter frame steps
  sequence sFrameOpen;
    $fell(adcCs_n);
  endsequence
  sequence sFrameBody;
    !adcCs_n [*8];
  endsequence
  AST_VERSION_READ: assert property (
    regRead && regAddr == ADDR_VERSION |=> regRdata == VERSION_ID)
    else $error("version read wrong");
  AST_CUT_AZ: assert property (
    (cut_reg[0] && overheat[0]) [*4] |-> !pwmOut[0])
    else $error("azimuth pwm not cut while hot");
  AST_CLR_AZ: assert property (
    clr_reg[0] [*3] ##0 (regRead && regAddr == ADDR_POS_AZ) |=> regRdata == 32'h0)
    else $error("held azimuth counter not zero");
  AST_CLR_BOTH: assert property (
    (clr_reg == 2'h3) [*3] ##0 (regRead && regAddr == ADDR_POS_BOTH) |=> regRdata == 32'h0)
    else $error("held counters not zero");
  AST_FRAME_HOLD: assert property (
    sFrameOpen |-> sFrameBody)
    else $error("adc frame cut short");
  AST_FRAME_END: assert property (
    sFrameOpen |-> ##[110:400] adcCs_n)
    else $error("adc frame never ends");
  AST_CHAN_STEADY: assert property (
    !adcCs_n && !$past(adcCs_n) |-> $stable(adcChan))
    else $error("adc channel moved in frame");
  AST_SCLK_IDLE: assert property (
    adcCs_n |-> !adcSclk)
    else $error("adc clock toggled while deselected");
  AST_DRIVE_LAG: assert property (
    lag_reg < LAG_MAX)
    else $error("direction or brake not applied");
  AST_IRQ_MASKED: assert property (
    irq |-> mask_reg != 4'h0)
    else $error("interrupt with all sources masked");
endmodule // trio_io_checker
bind trio_io_top trio_io_checker #(.VERSION_ID(VERSION_ID)) u_checker (
  .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .overheat(overheat), .pwmOut(pwmOut), .dirOut(dirOut), .brakeOut(brakeOut),
  .adcCs_n(adcCs_n), .adcSclk(adcSclk), .adcChan(adcChan), .irq(irq)
);
`default_nettype wire
